// File: verilog/atc_pkg.sv
package atc_pkg;
    // Register offsets (I/O space)
    localparam logic [7:0] ADDR_CONTROL  = 8'h33;
    localparam logic [7:0] ADDR_COUNT    = 8'h32;
    localparam logic [7:0] ADDR_COMPARE  = 8'h31;
    localparam logic [7:0] ADDR_ASYNC    = 8'h30;
    localparam logic [7:0] ADDR_SPECIAL  = 8'h20;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h39;
    localparam logic [7:0] ADDR_IRQ_FLAG = 8'h38;
    // Control register fields
    localparam int CTL_FORCE   = 7;
    localparam int CTL_WAVE_HI = 6;
    localparam int CTL_COM_HI  = 5;
    localparam int CTL_COM_LO  = 4;
    localparam int CTL_WAVE_LO = 3;
    localparam int CTL_CS_HI   = 2;
    localparam logic [7:0] CTL_RESET    = 8'h00;
    localparam logic [7:0] CTL_RD_MASK  = 8'h7F;
    // Async status fields
    localparam int AS_SELECT  = 3;
    localparam int AS_CNT_UB  = 2;
    localparam int AS_CMP_UB  = 1;
    localparam int AS_CTL_UB  = 0;
    // Special function register fields
    localparam int SF_PSR     = 0;
    // Interrupt enable and flag fields
    localparam int IRQ_CMP    = 1;
    localparam int IRQ_OVF    = 0;
    // Counter constants
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hFF;
    localparam logic [7:0] ZERO8      = 8'h00;
    localparam int PRESC_W = 10;
    localparam int SYNC_STAGES = 3;
    // Wave modes
    typedef enum logic [1:0] {
        WAVE_NORMAL = 2'b00,
        WAVE_PCPWM  = 2'b01,
        WAVE_CTC    = 2'b10,
        WAVE_FAST   = 2'b11
    } atc_wave_e;
    // Compare output modes
    localparam logic [1:0] COM_OFF    = 2'b00;
    localparam logic [1:0] COM_TOGGLE = 2'b01;
    localparam logic [1:0] COM_CLEAR  = 2'b10;
    localparam logic [1:0] COM_SET    = 2'b11;
    // Clock select
    localparam logic [2:0] CS_STOP  = 3'h0;
    localparam logic [2:0] CS_DIV1  = 3'h1;
    localparam logic [2:0] CS_DIV8  = 3'h2;
    localparam logic [2:0] CS_DIV32 = 3'h3;
    localparam logic [2:0] CS_DIV64 = 3'h4;
    localparam logic [2:0] CS_DIV128 = 3'h5;
    localparam logic [2:0] CS_DIV256 = 3'h6;
    localparam logic [2:0] CS_DIV1024 = 3'h7;
    // Prescaler taps (bit index whose rollover gives the divide)
    localparam int TAP8 = 2;
    localparam int TAP32 = 4;
    localparam int TAP64 = 5;
    localparam int TAP128 = 6;
    localparam int TAP256 = 7;
    localparam int TAP1024 = 9;
endpackage

// File: verilog/atc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module atc_sync
    import atc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic clkEn,
    input  wire logic dIn,
    output var  logic dOut
);
    logic [SYNC_STAGES-1:0] stage_q;
    logic [SYNC_STAGES-1:0] stage_d;

    always_comb begin
        stage_d = {stage_q[SYNC_STAGES-2:0], dIn};
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage_q <= '0;
        end else if (clkEn) begin
            stage_q <= stage_d;
        end
    end

    assign dOut = stage_q[SYNC_STAGES-1];
endmodule // atc_sync
`default_nettype wire

// File: verilog/atc_edge.sv
`timescale 1ns/1ps
`default_nettype none
module atc_edge
    import atc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic clkEn,
    input  wire logic level,
    output var  logic rise
);
    logic last_q;
    logic last_d;

    always_comb begin
        last_d = level;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            last_q <= 1'b0;
        end else if (clkEn) begin
            last_q <= last_d;
        end
    end

    assign rise = level & ~last_q;
endmodule // atc_edge
`default_nettype wire

// File: verilog/atc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Phase PWM: compare at bottom holds output low, at max high; mode 11 the reverse.
// - Compare moving off max forces output to the up-count match level.
// - Start above compare still applies the missed up-count output change.
// - Counter advances on a tick enable from the chosen source.
// - Async writes sit in holding registers, land after two crystal edges.
// - Counter, compare and control each have their own holding register.
// - One busy flag per async register, cleared once it has landed.
// - Pending compare or counter write blocks compare match in async.
// - Interrupt logic needs one crystal cycle before a new interrupt.
// - Crystal oscillator runs in all sleeps but power-down and standby.
// - Async wake-up starts on the next timer cycle after the event.
// - Counter reads come from a copy refreshed each core cycle, or each crystal rising edge in async.
// - Async flags reach the core after three core plus one timer cycle.
// - Compare output changes on the core clock, synchronised.
// - Source defaults to core clock; async select takes crystal pins.
// - Prescaler gives 1, 8, 32, 64, 128, 256, 1024 and stop.
// - Writing the prescaler reset bit restarts the division phase.
// - Control: b7 force, b6/b3 wave mode, b5:4 out mode, b2:0 clock.
// - Wave modes: normal, phase PWM, clear on match, fast PWM.
// - Clock select codes 0 to 7 map stop, 1, 8, 32 ... 1024.
// - Force compare acts only outside PWM, no irq, reads zero.
// - Phase PWM mode 10 clears up, sets down; 11 reverse; 00 off.
module atc_timer
    import atc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       clkEn,
    input  wire logic [7:0] ioAddr,
    input  wire logic [7:0] ioWrData,
    input  wire logic       ioWrEn,
    input  wire logic       ioRdEn,
    output var  logic [7:0] ioRdData_q,
    input  wire logic       crystal_input_pin,
    input  wire logic       sleepDeep,
    output var  logic       crystal_output_pin,
    output var  logic       crystalPinsOwned_q,
    output var  logic       oscRun_q,
    output var  logic       compare_output_pin,
    output var  logic       compareOutEn_q,
    output var  logic       irqCompare_q,
    output var  logic       irqOverflow_q,
    output var  logic       wakeReq_q
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] ctl_q, ctl_d, cmp_q, cmp_d, cnt_q, cnt_d;
    logic [7:0] cmpBuf_q, cmpBuf_d;
    logic [7:0] holdCnt_q, holdCnt_d, holdCmp_q, holdCmp_d;
    logic [7:0] holdCtl_q, holdCtl_d, cntCopy_q, cntCopy_d;
    logic [2:0] busy_q, busy_d, pend_q, pend_d;
    logic [1:0] landCnt_q, landCnt_d;
    logic       asyncSel_q, asyncSel_d, downCnt_q, downCnt_d;
    logic       outBit_q, outBit_d, cntWrBlk_q, cntWrBlk_d;
    logic [1:0] irqEn_q, irqEn_d, irqFlag_q, irqFlag_d;
    logic       irqArmed_q, irqArmed_d;
    logic [PRESC_W-1:0] presc_q, presc_d;
    logic [7:0] rdData_d;
    logic       wake_d;

    // ------------------------------------------------------------
    // Crystal edge detection
    // ------------------------------------------------------------
    logic xtalSync, xtalRise;
    atc_sync u_xtal_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .dIn      (crystal_input_pin),
        .dOut     (xtalSync)
    );
    atc_edge u_xtal_edge (
        .core_clk (core_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .level    (xtalSync),
        .rise     (xtalRise)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [1:0] wave;
    logic [1:0] comMode;
    logic [2:0] clkSel;
    logic       srcTick, tick, presRst, forceStrobe;
    logic       wrCtl, wrCnt, wrCmp, isPwm, match, cmpPend;
    assign wave    = {ctl_q[CTL_WAVE_HI], ctl_q[CTL_WAVE_LO]};
    assign comMode = ctl_q[CTL_COM_HI:CTL_COM_LO];
    assign clkSel  = ctl_q[CTL_CS_HI:0];
    assign isPwm   = wave[0];
    assign srcTick = asyncSel_q ? xtalRise : 1'b1;
    assign presRst = ioWrEn && ioAddr == ADDR_SPECIAL && ioWrData[SF_PSR];
    assign wrCtl   = ioWrEn && ioAddr == ADDR_CONTROL;
    assign wrCnt   = ioWrEn && ioAddr == ADDR_COUNT;
    assign wrCmp   = ioWrEn && ioAddr == ADDR_COMPARE;
    assign forceStrobe = wrCtl && ioWrData[CTL_FORCE] && !ioWrData[CTL_WAVE_LO];
    assign cmpPend = asyncSel_q && (busy_q[AS_CMP_UB] || busy_q[AS_CNT_UB]);
    assign match   = cnt_q == cmp_q && !cmpPend && !cntWrBlk_q;

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    always_comb begin
        presc_d = presc_q;
        tick = 1'b0;
        if (presRst) begin
            presc_d = '0;
        end else if (srcTick) begin
            presc_d = presc_q + 1'b1;
        end
        if (srcTick) begin
            case (clkSel)
                CS_STOP:    tick = 1'b0;
                CS_DIV1:    tick = 1'b1;
                CS_DIV8:    tick = &presc_q[TAP8:0];
                CS_DIV32:   tick = &presc_q[TAP32:0];
                CS_DIV64:   tick = &presc_q[TAP64:0];
                CS_DIV128:  tick = &presc_q[TAP128:0];
                CS_DIV256:  tick = &presc_q[TAP256:0];
                default:    tick = &presc_q[TAP1024:0];
            endcase
        end
    end

    // ------------------------------------------------------------
    // Async write path
    // ------------------------------------------------------------
    always_comb begin
        asyncSel_d = asyncSel_q;
        holdCnt_d = holdCnt_q;
        holdCmp_d = holdCmp_q;
        holdCtl_d = holdCtl_q;
        busy_d = busy_q;
        pend_d = pend_q;
        landCnt_d = landCnt_q;
        if (ioWrEn && ioAddr == ADDR_ASYNC) begin
            asyncSel_d = ioWrData[AS_SELECT];
        end
        if (asyncSel_q) begin
            if (wrCnt) begin
                holdCnt_d = ioWrData;
                busy_d[AS_CNT_UB] = 1'b1;
            end
            if (wrCmp) begin
                holdCmp_d = ioWrData;
                busy_d[AS_CMP_UB] = 1'b1;
            end
            if (wrCtl) begin
                holdCtl_d = ioWrData & CTL_RD_MASK;
                busy_d[AS_CTL_UB] = 1'b1;
            end
            if (xtalRise) begin
                if (|busy_q) begin
                    landCnt_d = landCnt_q + 1'b1;
                end
                if (landCnt_q == 2'd1) begin
                    pend_d = busy_q; // landed after second edge
                    busy_d = (busy_d & ~busy_q) | {wrCnt, wrCmp, wrCtl};
                    landCnt_d = 2'd0;
                end
            end else begin
                pend_d = 3'b000;
            end
        end else begin
            busy_d = 3'b000;
            pend_d = 3'b000;
            landCnt_d = 2'd0;
        end
    end

    // ------------------------------------------------------------
    // Counter and waveform
    // ------------------------------------------------------------
    always_comb begin
        ctl_d = ctl_q;
        cnt_d = cnt_q;
        cmp_d = cmp_q;
        cmpBuf_d = cmpBuf_q;
        downCnt_d = downCnt_q;
        outBit_d = outBit_q;
        cntWrBlk_d = cntWrBlk_q;
        if (tick) begin
            cntWrBlk_d = 1'b0;
            case (atc_wave_e'(wave))
                WAVE_PCPWM: begin
                    if (cnt_q == CNT_MAX) begin
                        downCnt_d = 1'b1;
                        cnt_d = cnt_q - 1'b1;
                        if (cmpBuf_q != cmp_q) begin
                            cmp_d = cmpBuf_q; // compare update at top
                        end
                    end else if (cnt_q == CNT_BOTTOM) begin
                        downCnt_d = 1'b0;
                        cnt_d = cnt_q + 1'b1;
                    end else begin
                        cnt_d = downCnt_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
                    end
                    if (cmp_q == CNT_BOTTOM) begin
                        outBit_d = comMode == COM_SET;
                    end else if (cmp_q == CNT_MAX) begin
                        outBit_d = comMode != COM_SET;
                        if (cnt_q == CNT_MAX && cmpBuf_q != CNT_MAX) begin
                            outBit_d = comMode == COM_SET;
                        end
                    end else if (match) begin
                        outBit_d = downCnt_q ^ (comMode == COM_SET);
                    end else if (!downCnt_q && cnt_q > cmp_q
                                 && outBit_q != (comMode == COM_SET)) begin
                        outBit_d = comMode == COM_SET;
                    end
                end
                WAVE_FAST: begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == CNT_MAX) begin
                        cmp_d = cmpBuf_q;
                        outBit_d = comMode != COM_SET;
                    end else if (match) begin
                        outBit_d = comMode == COM_SET;
                    end
                end
                WAVE_CTC: begin
                    cnt_d = match ? CNT_BOTTOM : cnt_q + 1'b1;
                    cmp_d = cmpBuf_q;
                end
                default: begin
                    cnt_d = cnt_q + 1'b1;
                    cmp_d = cmpBuf_q;
                end
            endcase
            if (!isPwm && match) begin
                outBit_d = comMode == COM_TOGGLE ? ~outBit_q
                         : comMode == COM_SET;
            end
        end
        if (forceStrobe) begin
            outBit_d = comMode == COM_TOGGLE ? ~outBit_q
                     : comMode == COM_SET;
        end
        if (asyncSel_q) begin
            if (pend_q[AS_CNT_UB]) begin
                cnt_d = holdCnt_q;
                cntWrBlk_d = 1'b1;
            end
            if (pend_q[AS_CMP_UB]) begin
                cmpBuf_d = holdCmp_q;
            end
            if (pend_q[AS_CTL_UB]) begin
                ctl_d = holdCtl_q;
            end
        end else begin
            if (wrCnt) begin
                cnt_d = ioWrData;
                cntWrBlk_d = 1'b1;
            end
            if (wrCmp) begin
                cmpBuf_d = ioWrData;
            end
            if (wrCtl) begin
                ctl_d = ioWrData & CTL_RD_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Counter copy, flags, readback
    // ------------------------------------------------------------
    logic ovfEvt, cmpEvt;
    assign ovfEvt = tick && (isPwm && !wave[1] ? cnt_q == CNT_BOTTOM
                                               : cnt_q == CNT_MAX);
    assign cmpEvt = tick && match;

    always_comb begin
        cntCopy_d = cntCopy_q;
        irqEn_d = irqEn_q;
        irqFlag_d = irqFlag_q;
        irqArmed_d = irqArmed_q;
        wake_d = 1'b0;
        rdData_d = ZERO8;
        if (!asyncSel_q || xtalRise) begin
            cntCopy_d = cnt_q;
            irqArmed_d = 1'b1;
        end
        if (ioWrEn && ioAddr == ADDR_IRQ_EN) begin
            irqEn_d = ioWrData[1:0];
        end
        if (ioWrEn && ioAddr == ADDR_IRQ_FLAG) begin
            irqFlag_d = irqFlag_q & ~ioWrData[1:0];
        end
        if (irqArmed_q) begin
            if (cmpEvt) begin
                irqFlag_d[IRQ_CMP] = 1'b1;
            end
            if (ovfEvt) begin
                irqFlag_d[IRQ_OVF] = 1'b1;
            end
        end
        if (asyncSel_q && |(irqFlag_d & irqEn_q)
            && !(|(irqFlag_q & irqEn_q))) begin
            wake_d = 1'b1;
            irqArmed_d = 1'b0;
        end
        if (ioRdEn) begin
            if (ioAddr == ADDR_CONTROL) begin
                rdData_d = ctl_q & CTL_RD_MASK;
            end else if (ioAddr == ADDR_COUNT) begin
                rdData_d = cntCopy_q;
            end else if (ioAddr == ADDR_COMPARE) begin
                rdData_d = cmpBuf_q;
            end else if (ioAddr == ADDR_ASYNC) begin
                rdData_d = {4'h0, asyncSel_q, busy_q};
            end else if (ioAddr == ADDR_IRQ_EN) begin
                rdData_d = {6'h00, irqEn_q};
            end else if (ioAddr == ADDR_IRQ_FLAG) begin
                rdData_d = {6'h00, irqFlag_q};
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctl_q <= CTL_RESET;
            cnt_q <= CNT_BOTTOM;
            cmp_q <= CNT_BOTTOM;
            cmpBuf_q <= CNT_BOTTOM;
            holdCnt_q <= ZERO8;
            holdCmp_q <= ZERO8;
            holdCtl_q <= ZERO8;
            cntCopy_q <= ZERO8;
            busy_q <= 3'b000;
            pend_q <= 3'b000;
            landCnt_q <= 2'd0;
            asyncSel_q <= 1'b0;
            downCnt_q <= 1'b0;
            outBit_q <= 1'b0;
            cntWrBlk_q <= 1'b0;
            irqEn_q <= 2'b00;
            irqFlag_q <= 2'b00;
            irqArmed_q <= 1'b1;
            presc_q <= '0;
            ioRdData_q <= ZERO8;
            wakeReq_q <= 1'b0;
            irqCompare_q <= 1'b0;
            irqOverflow_q <= 1'b0;
            compare_output_pin <= 1'b0;
            compareOutEn_q <= 1'b0;
            crystalPinsOwned_q <= 1'b0;
            oscRun_q <= 1'b0;
            crystal_output_pin <= 1'b0;
        end else if (clkEn) begin
            ctl_q <= ctl_d;
            cnt_q <= cnt_d;
            cmp_q <= cmp_d;
            cmpBuf_q <= cmpBuf_d;
            holdCnt_q <= holdCnt_d;
            holdCmp_q <= holdCmp_d;
            holdCtl_q <= holdCtl_d;
            cntCopy_q <= cntCopy_d;
            busy_q <= busy_d;
            pend_q <= pend_d;
            landCnt_q <= landCnt_d;
            asyncSel_q <= asyncSel_d;
            downCnt_q <= downCnt_d;
            outBit_q <= outBit_d;
            cntWrBlk_q <= cntWrBlk_d;
            irqEn_q <= irqEn_d;
            irqFlag_q <= irqFlag_d;
            irqArmed_q <= irqArmed_d;
            presc_q <= presc_d;
            ioRdData_q <= rdData_d;
            wakeReq_q <= wake_d;
            irqCompare_q <= irqFlag_d[IRQ_CMP] & irqEn_d[IRQ_CMP];
            irqOverflow_q <= irqFlag_d[IRQ_OVF] & irqEn_d[IRQ_OVF];
            compare_output_pin <= outBit_d;
            compareOutEn_q <= ctl_d[CTL_COM_HI:CTL_COM_LO] != COM_OFF;
            crystalPinsOwned_q <= asyncSel_d;
            oscRun_q <= asyncSel_d && !sleepDeep;
            crystal_output_pin <= ~xtalSync;
        end
    end
endmodule // atc_timer
`default_nettype wire

// File: verification/atc_xtal_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Watch crystal seen at the crystal input
// ----------------------------------------
module atc_xtal_model #(
    parameter int HALF_NS = 83
) (
    input  wire logic run,
    output var  logic xtal
);
    initial xtal = 1'b0;
    // Stands still whenever the device stops the oscillator
    always begin
        #(HALF_NS);
        if (run === 1'b1) begin
            xtal = ~xtal;
        end
    end
endmodule // atc_xtal_model
`default_nettype wire

// File: verification/atc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module atc_checker
    import atc_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       clkEn,
    input wire logic [7:0] ioAddr,
    input wire logic [7:0] ioWrData,
    input wire logic       ioWrEn,
    input wire logic       ioRdEn,
    input wire logic [7:0] ioRdData_q,
    input wire logic       sleepDeep,
    input wire logic       crystalPinsOwned_q,
    input wire logic       oscRun_q,
    input wire logic       compareOutEn_q,
    input wire logic       wakeReq_q
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    property p_rd_ctl;
        ioRdEn && clkEn && ioAddr == ADDR_CONTROL |=> !ioRdData_q[CTL_FORCE];
    endproperty
    a_rd_ctl: assert property (p_rd_ctl)
        else $error("control bit7 read as one");
    property p_rd_gap;
        ioRdEn && clkEn && ioAddr == 8'h00 |=> ioRdData_q == 8'h00;
    endproperty
    a_rd_gap: assert property (p_rd_gap)
        else $error("unmapped read not zero");
    property p_busy;
        ioWrEn && clkEn && ioAddr == ADDR_COMPARE && crystalPinsOwned_q
        ##2 ioRdEn && ioAddr == ADDR_ASYNC |=> ioRdData_q[AS_CMP_UB];
    endproperty
    a_busy: assert property (p_busy)
        else $error("compare busy not shown");
    property p_sleep;
        sleepDeep |=> !oscRun_q;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("oscillator runs in deep sleep");
    property p_own;
        oscRun_q |-> crystalPinsOwned_q;
    endproperty
    a_own: assert property (p_own)
        else $error("oscillator runs without async select");
    property p_own_rise;
        $rose(crystalPinsOwned_q) |-> $past(ioWrEn && ioAddr == ADDR_ASYNC);
    endproperty
    a_own_rise: assert property (p_own_rise)
        else $error("pins taken without select write");
    property p_wake_pulse;
        wakeReq_q |=> !wakeReq_q;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake request longer than one cycle");
    property p_wake_async;
        wakeReq_q |-> crystalPinsOwned_q;
    endproperty
    a_wake_async: assert property (p_wake_async)
        else $error("wake request outside async mode");
    property p_com_en;
        ioWrEn && clkEn && ioAddr == ADDR_CONTROL && !crystalPinsOwned_q
        && ioWrData[5:4] != 2'b00 |-> ##[1:3] compareOutEn_q;
    endproperty
    a_com_en: assert property (p_com_en)
        else $error("output mode not applied");
    c_wake: cover property (wakeReq_q);
    c_busy: cover property (p_busy);
    c_com: cover property ($rose(compareOutEn_q));
endmodule // atc_checker
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Testbench
// ----------------------------------------
module tb_top
    import atc_pkg::*;
;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       clkEn = 1'b1;
    logic [7:0] ioAddr = 8'h00;
    logic [7:0] ioWrData = 8'h00;
    logic       ioWrEn = 1'b0;
    logic       ioRdEn = 1'b0;
    logic       sleepDeep = 1'b0;
    logic       xtal;
    logic [7:0] ioRdData_q;
    logic       xtalOut, owned, oscRun, cmpPin, cmpEn, irqCmp, irqOvf;
    logic       wake;
    logic       wakeSeen = 1'b0;
    logic [7:0] d, v;
    int         err_total = 0;
    int         compares = 0;
    int         seed = 92;
    int         n, hi;
    int         divTab [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    int         cmpTab [6] = '{0, 255, 0, 255, 128, 128};
    int         comTab [6] = '{2, 2, 3, 3, 2, 3};
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (wake === 1'b1) wakeSeen <= 1'b1;
    atc_timer i_dut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
        .ioAddr(ioAddr), .ioWrData(ioWrData), .ioWrEn(ioWrEn),
        .ioRdEn(ioRdEn), .ioRdData_q(ioRdData_q),
        .crystal_input_pin(xtal), .sleepDeep(sleepDeep),
        .crystal_output_pin(xtalOut), .crystalPinsOwned_q(owned),
        .oscRun_q(oscRun), .compare_output_pin(cmpPin),
        .compareOutEn_q(cmpEn), .irqCompare_q(irqCmp),
        .irqOverflow_q(irqOvf), .wakeReq_q(wake));
    atc_xtal_model i_xtal (.run(oscRun), .xtal(xtal));
    function automatic int pwmHigh(input int c, input int m);
        int h;
        h = (c == 0) ? 0 : (c == 255) ? 510 : 2 * c;
        return (m == 3) ? 510 - h : h;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        compares++;
        if (got !== e) begin
            err_total++;
            $display("mismatch %0t got %h exp %h", $time, got, e);
        end
    endtask
    task automatic near(input logic [9:0] got, input int e, input int t);
        compares++;
        if ($isunknown(got) || got + t < e || got > e + t) begin
            err_total++;
            $display("mismatch %0t got %0d near %0d", $time, got, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge core_clk);
        ioAddr   <= a;
        ioWrData <= x;
        ioWrEn   <= 1'b1;
        @(posedge core_clk);
        ioWrEn   <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        @(posedge core_clk);
        ioAddr <= a;
        ioRdEn <= 1'b1;
        @(posedge core_clk);
        ioRdEn <= 1'b0;
        #1 x = ioRdData_q;
    endtask
    task automatic end_sim;
        $display("err_total %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(60000 * 10);
        err_total++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rd(ADDR_CONTROL, d);
        chk(d, CTL_RESET);
        rd(8'h00, d);
        chk(d, 8'h00);
        v = 8'($random(seed));
        wr(ADDR_CONTROL, v);
        rd(ADDR_CONTROL, d);
        chk(d, v & CTL_RD_MASK);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CONTROL, 8'h00);
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_SPECIAL, 8'h01);
            wr(ADDR_CONTROL, 8'(i));
            n = (divTab[i] < 8) ? 40 : 4 * divTab[i];
            repeat (n) @(posedge core_clk);
            rd(ADDR_COUNT, d);
            near(10'(d), divTab[i] == 0 ? 0 : n / divTab[i],
                divTab[i] == 1 ? 3 : 1);
        end
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_COMPARE, 8'(cmpTab[i]));
            wr(ADDR_CONTROL, 8'(comTab[i] * 16 + 9));
            repeat (1100) @(posedge core_clk);
            hi = 0;
            repeat (510) begin
                @(posedge core_clk);
                #1;
                if (cmpPin === 1'b1) hi++;
            end
            near(10'(hi), pwmHigh(cmpTab[i], comTab[i]), 2);
            chk(8'(cmpEn), 8'h01);
        end
        wr(ADDR_CONTROL, 8'h10);
        #1 v = 8'(cmpPin);
        wr(ADDR_CONTROL, 8'h90);
        repeat (3) @(posedge core_clk);
        #1 chk(8'(cmpPin), v ^ 8'h01);
        wr(ADDR_CONTROL, 8'h28);
        #1 v = 8'(cmpPin);
        wr(ADDR_CONTROL, 8'hA8);
        repeat (3) @(posedge core_clk);
        #1 chk(8'(cmpPin), v);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_ASYNC, 8'h08);
        #1 chk(8'(owned), 8'h01);
        v = 8'($random(seed));
        wr(ADDR_COUNT, v);
        wr(ADDR_COMPARE, 8'h40);
        rd(ADDR_ASYNC, d);
        chk(d, 8'h0E);
        n = 0;
        do begin
            rd(ADDR_ASYNC, d);
            n++;
        end while (d[AS_CNT_UB] !== 1'b0 && n < 200);
        chk(d, 8'h08);
        chk(8'(n * 2 + 4 >= 16), 8'h01);
        repeat (40) @(posedge core_clk);
        rd(ADDR_COUNT, d);
        chk(d, v);
        @(posedge core_clk);
        sleepDeep <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 chk(8'(oscRun), 8'h00);
        repeat (20) @(posedge core_clk);
        #1 chk(8'(xtalOut), 8'(!xtal));
        @(posedge core_clk);
        sleepDeep <= 1'b0;
        wr(ADDR_IRQ_FLAG, 8'h03);
        wr(ADDR_IRQ_EN, 8'h01);
        wr(ADDR_CONTROL, 8'h01);
        n = 0;
        while (irqOvf !== 1'b1 && n < 8000) begin
            @(posedge core_clk);
            n++;
        end
        #1 chk(8'(wakeSeen), 8'h01);
        wr(ADDR_IRQ_FLAG, 8'h01);
        @(posedge core_clk);
        #1 chk(8'(irqOvf), 8'h00);
        end_sim();
    end
endmodule // tb_top
bind atc_timer atc_checker i_chk (.core_clk(core_clk), .rst(rst),
    .clkEn(clkEn), .ioAddr(ioAddr), .ioWrData(ioWrData),
    .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .ioRdData_q(ioRdData_q),
    .sleepDeep(sleepDeep), .crystalPinsOwned_q(crystalPinsOwned_q),
    .oscRun_q(oscRun_q), .compareOutEn_q(compareOutEn_q),
    .wakeReq_q(wakeReq_q));
`default_nettype wire
